// [inc/sfic_map.svh]
`ifndef SFIC_MAP_SVH
`define SFIC_MAP_SVH
`define SFIC_OFF_EN_A      8'h02
`define SFIC_OFF_EN_B      8'h03
`define SFIC_OFF_WR_IDX    8'h04
`define SFIC_OFF_LOST      8'h05
`define SFIC_OFF_RD_IDX    8'h06
`define SFIC_OFF_DATA      8'h07
`define SFIC_OFF_CFG       8'h08
`define SFIC_BIT_AFULL_EN  7
`define SFIC_BIT_READY_EN  6
`define SFIC_BIT_AMB_EN    5
`define SFIC_BIT_PROX_EN   4
`define SFIC_BIT_COMP_EN   3
`define SFIC_BIT_SUPPLY_EN 7
`define SFIC_BIT_CLR_SEL   6
`define SFIC_BIT_AF_TYPE   5
`define SFIC_BIT_ROLL      4
`define SFIC_EN_A_MASK     8'hF8
`define SFIC_EN_B_MASK     8'h80
`define SFIC_CFG_MASK      8'h7F
`define SFIC_EN_RST        8'h00
`define SFIC_CFG_RST       8'h0F
`define SFIC_DEPTH         6'h20
`define SFIC_LOST_MAX      5'h1F
`define SFIC_PROX_SHIFT    11'h000
`define SFIC_STAGE_DEPTH   16
`endif

// [inc/sfic_pkg.sv]
package sfic_pkg;
   typedef struct packed {
      logic ambient_overflow;
      logic driver_noncompliant;
      logic supply_out_of_range;
   } sfic_evt_t;

   typedef struct packed {
      logic a_full;
      logic sample_ready;
      logic ambient_overflow;
      logic prox;
      logic driver_noncompliant;
      logic supply_out_of_range;
   } sfic_flags_t;

   typedef enum logic [1:0] {
      SFIC_NORMAL = 2'b01,
      SFIC_PROX   = 2'b10
   } sfic_mode_t;
endpackage

// [logic/sfic_top.sv]
`timescale 1ns/1ps
`include "sfic_map.svh"

module sfic_stage_fifo
   import sfic_pkg::*;
#(
   parameter int W = 8,
   parameter int D = 16
)
(
   input  wire logic         clk,       // Core clock
   input  wire logic         rst,       // Synchronous reset
   input  wire logic         s_valid,   // Producer has a word
   input  wire logic [W-1:0] s_data,    // Producer word
   output logic              s_ready_q, // Space available
   output logic              m_valid_q, // Word available
   output logic [W-1:0]      m_data,    // Head word
   input  wire logic         m_ready    // Consumer takes head
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem [D];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0]   cnt_q;
   logic [AW:0]   cnt_d;
   logic          put;
   logic          take;

   assign put  = s_valid && s_ready_q;
   assign take = m_valid_q && m_ready;
   assign m_data = mem[rp_q];

   always_comb
   begin
      cnt_d = cnt_q;
      if (put && !take)
         cnt_d = cnt_q + 1'b1;
      else if (take && !put)
         cnt_d = cnt_q - 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (put)
         mem[wp_q] <= s_data;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wp_q      <= '0;
         rp_q      <= '0;
         cnt_q     <= '0;
         s_ready_q <= 1'b0;
         m_valid_q <= 1'b0;
      end
      else
      begin
         if (put)
            wp_q <= wp_q + 1'b1;
         if (take)
            rp_q <= rp_q + 1'b1;
         cnt_q     <= cnt_d;
         s_ready_q <= (cnt_d != D[AW:0]);
         m_valid_q <= (cnt_d != '0);
      end
   end
endmodule

module sfic_top
   import sfic_pkg::*;
(
   input  wire logic         clk,                 // 200 MHz core clock
   input  wire logic         rst,                 // Synchronous reset, high
   input  wire logic         smp_valid,           // New converted sample byte
   input  wire logic [7:0]   smp_data,            // Sample byte
   output logic              smp_ready_q,         // Staging buffer has room
   input  wire sfic_evt_t    evt,                 // Monitor event pulses
   input  wire logic         prox_valid,          // First-emitter reading strobe
   input  wire logic [18:0]  prox_reading,        // First-emitter reading
   input  wire logic [7:0]   proximity_threshold, // Proximity threshold value
   input  wire logic         status1_rd,          // Status one was read
   input  wire logic         status2_rd,          // Status two was read
   input  wire logic [7:0]   reg_addr,            // Register offset
   input  wire logic         reg_wr,              // Register write strobe
   input  wire logic         reg_rd,              // Register read strobe
   input  wire logic [7:0]   reg_wdata,           // Write data
   output logic [7:0]        reg_rdata_q,         // Read data
   output sfic_flags_t       flags_q,             // Event flags
   output logic              prox_mode_q,         // Single pilot exposure
   output logic              irq_n_q              // Interrupt request, low
);
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   logic [7:0]  mem [32];
   logic [7:0]  en_a_q;
   logic [7:0]  en_b_q;
   logic [7:0]  cfg_q;
   logic [4:0]  wr_q;
   logic [4:0]  rd_q;
   logic        full_q;
   logic [4:0]  lost_q;
   logic        af_was;
   sfic_mode_t  mode_q;
   logic        st_valid;
   logic [7:0]  st_data;
   logic        drain_ok;
   logic        push;
   logic        store;
   logic        roll;
   logic        empty;
   logic        pop;
   logic [5:0]  cnt;
   logic [5:0]  cnt_after;
   logic        af_cond;
   logic        af_set;
   logic        data_rd;
   logic        prox_en;
   logic        to_normal;
   logic [18:0] prox_limit;

   // Host accesses take the cycle; drain waits so indexes have one writer
   assign drain_ok = !(reg_rd || reg_wr);

   sfic_stage_fifo #(
      .W (8),
      .D (`SFIC_STAGE_DEPTH)
   ) u_stage (
      .clk       (clk),
      .rst       (rst),
      .s_valid   (smp_valid),
      .s_data    (smp_data),
      .s_ready_q (smp_ready_q),
      .m_valid_q (st_valid),
      .m_data    (st_data),
      .m_ready   (drain_ok)
   );

   assign push    = st_valid && drain_ok;
   assign empty   = (wr_q == rd_q) && !full_q;
   assign roll    = cfg_q[`SFIC_BIT_ROLL] || (mode_q == SFIC_PROX);
   assign store   = push && (!full_q || roll);
   assign data_rd = reg_rd && hit(reg_addr, `SFIC_OFF_DATA);
   assign pop     = data_rd && !empty;
   assign cnt     = full_q ? `SFIC_DEPTH : {1'b0, wr_q - rd_q};
   assign cnt_after = (store && !full_q) ? cnt + 6'h01 : cnt;
   assign af_cond = cnt_after >= (`SFIC_DEPTH - {2'b00, cfg_q[3:0]});
   assign prox_en = en_a_q[`SFIC_BIT_PROX_EN];
   assign prox_limit = {proximity_threshold, `SFIC_PROX_SHIFT};
   assign to_normal = prox_en && prox_valid && (mode_q == SFIC_PROX)
                      && !(prox_reading < prox_limit);
   // Judged on the count before this store, so a pop or an index write that
   // drops the count below the threshold makes the next crossing a fresh one
   assign af_was  = cnt >= (`SFIC_DEPTH - {2'b00, cfg_q[3:0]});
   // Repeat type re-fires every sample; once type only on a fresh crossing
   assign af_set  = store && af_cond
                    && (!cfg_q[`SFIC_BIT_AF_TYPE] || !af_was);

   always_ff @(posedge clk)
   begin
      if (store)
         mem[wr_q] <= st_data;
   end

   // Register file
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         en_a_q <= `SFIC_EN_RST;
         en_b_q <= `SFIC_EN_RST;
         cfg_q  <= `SFIC_CFG_RST;
      end
      else if (reg_wr)
      begin
         if (hit(reg_addr, `SFIC_OFF_EN_A))
            en_a_q <= reg_wdata & `SFIC_EN_A_MASK;
         if (hit(reg_addr, `SFIC_OFF_EN_B))
            en_b_q <= reg_wdata & `SFIC_EN_B_MASK;
         if (hit(reg_addr, `SFIC_OFF_CFG))
            cfg_q <= reg_wdata & `SFIC_CFG_MASK;
      end
   end

   // Queue indexes and fullness
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wr_q   <= 5'h00;
         rd_q   <= 5'h00;
         full_q <= 1'b0;
      end
      else if (reg_wr && hit(reg_addr, `SFIC_OFF_WR_IDX))
      begin
         wr_q   <= reg_wdata[4:0];
         full_q <= 1'b0;
      end
      else if (reg_wr && hit(reg_addr, `SFIC_OFF_RD_IDX))
      begin
         rd_q   <= reg_wdata[4:0];
         full_q <= 1'b0;
      end
      else if (pop)
      begin
         rd_q   <= rd_q + 5'h01;
         full_q <= 1'b0;
      end
      else if (store)
      begin
         wr_q <= wr_q + 5'h01;
         if (full_q)
            rd_q <= rd_q + 5'h01;
         else
            full_q <= (wr_q + 5'h01 == rd_q);
      end
   end

   // Samples lost: dropped when stopping, overwritten when rolling
   always_ff @(posedge clk)
   begin
      if (rst)
         lost_q <= 5'h00;
      else if (push && full_q && lost_q != `SFIC_LOST_MAX)
         lost_q <= lost_q + 5'h01;
   end

   // Acquisition mode follows each first-emitter reading
   always_ff @(posedge clk)
   begin
      if (rst)
         mode_q <= SFIC_NORMAL;
      else if (!prox_en)
         mode_q <= SFIC_NORMAL;
      else if (prox_valid)
      begin
         case (mode_q)
            SFIC_NORMAL:
               if (prox_reading < prox_limit)
                  mode_q <= SFIC_PROX;
            SFIC_PROX:
               if (!(prox_reading < prox_limit))
                  mode_q <= SFIC_NORMAL;
            default:
               mode_q <= SFIC_NORMAL;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         prox_mode_q <= 1'b0;
      else
         prox_mode_q <= (mode_q == SFIC_PROX);
   end

   // Event flags: a set in the same cycle as a clear wins
   always_ff @(posedge clk)
   begin
      if (rst)
         flags_q <= '0;
      else
      begin
         if (af_set)
            flags_q.a_full <= 1'b1;
         else if (status1_rd || (data_rd && cfg_q[`SFIC_BIT_CLR_SEL]))
            flags_q.a_full <= 1'b0;
         if (store)
            flags_q.sample_ready <= 1'b1;
         else if (status1_rd || (data_rd && cfg_q[`SFIC_BIT_CLR_SEL]))
            flags_q.sample_ready <= 1'b0;
         if (evt.ambient_overflow)
            flags_q.ambient_overflow <= 1'b1;
         else if (status1_rd)
            flags_q.ambient_overflow <= 1'b0;
         if (to_normal)
            flags_q.prox <= 1'b1;
         else if (status1_rd)
            flags_q.prox <= 1'b0;
         if (evt.driver_noncompliant)
            flags_q.driver_noncompliant <= 1'b1;
         else if (status1_rd)
            flags_q.driver_noncompliant <= 1'b0;
         if (evt.supply_out_of_range)
            flags_q.supply_out_of_range <= 1'b1;
         else if (status2_rd)
            flags_q.supply_out_of_range <= 1'b0;
      end
   end

   // Line is registered, so it follows the flags by one cycle
   always_ff @(posedge clk)
   begin
      if (rst)
         irq_n_q <= 1'b1;
      else
         irq_n_q <= !((flags_q.a_full && en_a_q[`SFIC_BIT_AFULL_EN])
                   || (flags_q.sample_ready && en_a_q[`SFIC_BIT_READY_EN])
                   || (flags_q.ambient_overflow && en_a_q[`SFIC_BIT_AMB_EN])
                   || (flags_q.prox && en_a_q[`SFIC_BIT_PROX_EN])
                   || (flags_q.driver_noncompliant && en_a_q[`SFIC_BIT_COMP_EN])
                   || (flags_q.supply_out_of_range && en_b_q[`SFIC_BIT_SUPPLY_EN]));
   end

   // Read data: unmapped offsets read zero; an empty queue reads zero
   always_ff @(posedge clk)
   begin
      if (rst)
         reg_rdata_q <= 8'h00;
      else if (reg_rd)
      begin
         case (reg_addr)
            `SFIC_OFF_EN_A:   reg_rdata_q <= en_a_q;
            `SFIC_OFF_EN_B:   reg_rdata_q <= en_b_q;
            `SFIC_OFF_WR_IDX: reg_rdata_q <= {3'h0, wr_q};
            `SFIC_OFF_LOST:   reg_rdata_q <= {3'h0, lost_q};
            `SFIC_OFF_RD_IDX: reg_rdata_q <= {3'h0, rd_q};
            `SFIC_OFF_DATA:   reg_rdata_q <= empty ? 8'h00 : mem[rd_q];
            `SFIC_OFF_CFG:    reg_rdata_q <= cfg_q;
            default:          reg_rdata_q <= 8'h00;
         endcase
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_push_full_stop;
      push && full_q && !roll;
   endsequence

   sequence s_push_full_roll;
      push && full_q && roll && !pop && !reg_wr;
   endsequence

   a_wr_idx_adv: assert property (store && !pop && !reg_wr |=> wr_q == $past(wr_q) + 5'h01)
      else $error("write index did not advance on push");
   a_lost_sat: assert property (lost_q == `SFIC_LOST_MAX |=> lost_q == `SFIC_LOST_MAX)
      else $error("lost counter wrapped");
   a_rd_idx_pop: assert property (pop && !reg_wr |=> rd_q == $past(rd_q) + 5'h01)
      else $error("read index did not advance on pop");
   a_stop_full: assert property (s_push_full_stop |=> wr_q == $past(wr_q) && full_q)
      else $error("stop-on-full moved write index");
   a_roll_both: assert property (s_push_full_roll |=> wr_q == $past(wr_q) + 5'h01
                                 && rd_q == $past(rd_q) + 5'h01)
      else $error("roll-over did not move both indexes");
   a_irq_gate: assert property (flags_q == '0 |=> irq_n_q)
      else $error("interrupt without a flag");
   a_ready_gate: assert property (flags_q.sample_ready && !en_a_q[6] && flags_q[5] == 1'b0
                                  && flags_q[3:0] == 4'h0 |=> irq_n_q)
      else $error("masked sample-ready raised interrupt");
   a_prox_flag: assert property (to_normal |=> flags_q.prox && mode_q == SFIC_NORMAL)
      else $error("proximity exit did not set flag");
   a_af_clear: assert property (status1_rd && !af_set |=> !flags_q.a_full)
      else $error("status read did not clear almost-full");
   a_amb_clear: assert property (status1_rd && !evt.ambient_overflow |=> !flags_q.ambient_overflow)
      else $error("status read did not clear ambient flag");

   // Almost-full, lost count, proximity entry and proximity roll-over
   a_lost_count: assert property (push && full_q && lost_q != `SFIC_LOST_MAX |=> lost_q == $past(lost_q) + 5'h01)
      else $error("lost counter did not count a lost sample");
   a_af_repeat: assert property (store && af_cond && !cfg_q[`SFIC_BIT_AF_TYPE] |=> flags_q.a_full)
      else $error("repeat almost-full did not set");
   a_af_once: assert property (store && af_was && cfg_q[`SFIC_BIT_AF_TYPE] && !flags_q.a_full |=> !flags_q.a_full)
      else $error("once almost-full set again without a new crossing");
   a_af_data_clr: assert property (data_rd && cfg_q[`SFIC_BIT_CLR_SEL] |=> !flags_q.a_full)
      else $error("data read did not clear almost-full");
   a_mode_enter: assert property (prox_en && prox_valid && prox_reading < prox_limit |=> mode_q == SFIC_PROX)
      else $error("low reading did not enter proximity mode");
   a_roll_prox: assert property (push && full_q && mode_q == SFIC_PROX |-> store)
      else $error("proximity mode dropped a sample on full");
endmodule

// [test/sfic_host_model.sv]
`timescale 1ns/1ps
module sfic_host_model (
   input  wire logic       clk,         // Core clock
   output logic [7:0]      reg_addr,    // Register offset
   output logic            reg_wr,      // Write strobe
   output logic            reg_rd,      // Read strobe
   output logic [7:0]      reg_wdata,   // Write data
   output logic            status1_rd,  // Status one read
   output logic            status2_rd,  // Status two read
   input  wire logic [7:0] reg_rdata_q  // Read data
);
   initial
   begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
      status1_rd = 1'b0;
      status2_rd = 1'b0;
   end

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // Data is taken at the negedge, well after the registered answer lands
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      d = reg_rdata_q;
   endtask

   task st(input int n);
      @(posedge clk);
      status1_rd <= (n == 1);
      status2_rd <= (n == 2);
      @(posedge clk);
      status1_rd <= 1'b0;
      status2_rd <= 1'b0;
   endtask
endmodule

// [test/sfic_top_tb_top.sv]
`timescale 1ns/1ps
`define CK(a, e) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
   $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module sfic_top_tb_top
   import sfic_pkg::*;
;
   logic        clk;
   logic        rst;
   logic        smp_valid;
   logic [7:0]  smp_data;
   logic        smp_ready_q;
   sfic_evt_t   evt;
   logic        prox_valid;
   logic [18:0] prox_reading;
   logic [7:0]  thr;
   logic        s1;
   logic        s2;
   logic [7:0]  reg_addr;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_wdata;
   logic [7:0]  reg_rdata_q;
   sfic_flags_t flg;
   logic        prox_mode_q;
   logic        irq_n_q;
   int          num_errors = 0;
   int          n_compared = 0;
   int          cyc = 0;

   sfic_top sfic_top_i (.clk(clk), .rst(rst), .smp_valid(smp_valid), .smp_data(smp_data),
      .smp_ready_q(smp_ready_q), .evt(evt), .prox_valid(prox_valid), .prox_reading(prox_reading),
      .proximity_threshold(thr), .status1_rd(s1), .status2_rd(s2), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
      .flags_q(flg), .prox_mode_q(prox_mode_q), .irq_n_q(irq_n_q));

   sfic_host_model sfic_host_model_i (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .status1_rd(s1), .status2_rd(s2),
      .reg_rdata_q(reg_rdata_q));

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task close_out;
      if (num_errors == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Generous ceiling: the whole sequence needs about a thousand cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         num_errors++;
         $display("[ERR] %0t timeout", $time);
         close_out;
      end
   end

   task wt(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   task rs;
      @(posedge clk);
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
   endtask

   task w(input logic [7:0] a, input logic [7:0] d);
      sfic_host_model_i.wr(a, d);
   endtask

   task rdc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      sfic_host_model_i.rd(a, d);
      `CK(d, e)
   endtask

   // Valid stays up across back-to-back bytes; the drain is given time after
   task push(input int n, input logic [7:0] b);
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk);
         smp_valid <= 1'b1;
         smp_data <= 8'(b + i);
         @(negedge clk);
         while (!smp_ready_q) @(negedge clk);
      end
      @(posedge clk);
      smp_valid <= 1'b0;
      wt(40);
   endtask

   task t_regs;
      for (int a = 2; a < 8; a++) rdc(8'(a), 8'h00);
      rdc(8'h08, 8'h0F);
      rdc(8'h0C, 8'h00);
      w(8'h02, 8'hFF);
      w(8'h03, 8'hFF);
      w(8'h08, 8'hFF);
      w(8'h05, 8'hFF);
      rdc(8'h02, 8'hF8);
      rdc(8'h03, 8'h80);
      rdc(8'h08, 8'h7F);
      rdc(8'h05, 8'h00);
   endtask

   task t_rw;
      rs;
      w(8'h02, 8'h40);
      push(3, 8'hA0);
      rdc(8'h04, 8'h03);
      `CK(smp_ready_q, 1'b1)
      `CK(flg.sample_ready, 1'b1)
      `CK(irq_n_q, 1'b0)
      w(8'h02, 8'h00);
      wt(2);
      `CK(irq_n_q, 1'b1)
      for (int i = 0; i < 3; i++) rdc(8'h07, 8'(8'hA0 + i));
      rdc(8'h06, 8'h03);
      `CK(flg.sample_ready, 1'b1)
      w(8'h06, 8'h01);
      rdc(8'h07, 8'hA1);
      sfic_host_model_i.st(1);
      wt(2);
      `CK(flg.sample_ready, 1'b0)
   endtask

   task t_full;
      rs;
      w(8'h02, 8'h80);
      push(16, 8'h00);
      `CK(flg.a_full, 1'b0)
      push(1, 8'h10);
      `CK(flg.a_full, 1'b1)
      `CK(irq_n_q, 1'b0)
      rdc(8'h07, 8'h00);
      `CK(flg.a_full, 1'b1)
      sfic_host_model_i.st(1);
      wt(2);
      `CK(flg.a_full, 1'b0)
      push(1, 8'h11);
      `CK(flg.a_full, 1'b1)
      push(15, 8'h12);
      push(33, 8'hC0);
      rdc(8'h04, 8'h01);
      rdc(8'h05, 8'h1F);
      rdc(8'h07, 8'h01);
   endtask

   task t_once;
      rs;
      w(8'h08, 8'h6F);
      push(17, 8'h00);
      `CK(flg.a_full, 1'b1)
      rdc(8'h07, 8'h00);
      `CK(flg.a_full, 1'b0)
      sfic_host_model_i.st(1);
      push(1, 8'h11);
      `CK(flg.a_full, 1'b1)
      sfic_host_model_i.st(1);
      push(1, 8'h12);
      `CK(flg.a_full, 1'b0)
   endtask

   task t_roll;
      rs;
      w(8'h08, 8'h1F);
      push(32, 8'h00);
      push(1, 8'h20);
      rdc(8'h04, 8'h01);
      rdc(8'h06, 8'h01);
      rdc(8'h05, 8'h01);
      rdc(8'h07, 8'h01);
   endtask

   task t_evt;
      rs;
      @(posedge clk);
      evt <= 3'b111;
      @(posedge clk);
      evt <= '0;
      wt(3);
      `CK({flg.ambient_overflow, flg.driver_noncompliant, flg.supply_out_of_range, irq_n_q}, 4'hF)
      w(8'h02, 8'h20);
      wt(2);
      `CK(irq_n_q, 1'b0)
      w(8'h02, 8'h08);
      wt(2);
      `CK(irq_n_q, 1'b0)
      w(8'h02, 8'h00);
      w(8'h03, 8'h80);
      wt(2);
      `CK(irq_n_q, 1'b0)
      sfic_host_model_i.st(1);
      wt(2);
      `CK({flg.ambient_overflow, flg.driver_noncompliant, flg.supply_out_of_range}, 3'b001)
      sfic_host_model_i.st(2);
      wt(2);
      `CK(irq_n_q, 1'b1)
   endtask

   task pv(input logic [18:0] r);
      @(posedge clk);
      prox_valid <= 1'b1;
      prox_reading <= r;
      @(posedge clk);
      prox_valid <= 1'b0;
      wt(3);
   endtask

   task t_prox;
      rs;
      w(8'h02, 8'h10);
      @(posedge clk);
      thr <= 8'h03;
      pv(19'd6143);
      `CK(prox_mode_q, 1'b1)
      `CK(flg.prox, 1'b0)
      push(33, 8'h00);
      rdc(8'h04, 8'h01);
      rdc(8'h05, 8'h01);
      pv(19'd6144);
      `CK(prox_mode_q, 1'b0)
      `CK(flg.prox, 1'b1)
      `CK(irq_n_q, 1'b0)
   endtask

   initial
   begin
      rst = 1'b1;
      smp_valid = 1'b0;
      smp_data = 8'h00;
      evt = '0;
      prox_valid = 1'b0;
      prox_reading = '0;
      thr = 8'h01;
      rs;
      t_regs;
      t_rw;
      t_full;
      t_once;
      t_roll;
      t_evt;
      t_prox;
      close_out;
   end
endmodule
